// ---- bench/slave_tx_model.sv ----
`timescale 1ns/100ps
module slave_tx_model #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] FIRST = 8'hA5
) (
  input wire logic scl_i, // clock line level
  input wire logic sda_i, // data line level
  output logic sda_oe_o // high while pulling data low
);
  logic [1:0] st = 2'd0;
  logic [3:0] cnt = 4'd0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = FIRST;
  logic hit = 1'b0;
  logic mack = 1'b0;
  initial sda_oe_o = 1'b0;
  // start on the wire restarts the frame, stop ends it
  always @(negedge sda_i) if (scl_i) begin
    st = 2'd1;
    cnt = 4'd0;
  end
  always @(posedge sda_i) if (scl_i) st = 2'd0;
  always @(posedge scl_i) if (st != 2'd0) begin
    sh = {sh[6:0], sda_i};
    cnt = cnt + 4'd1;
    mack = !sda_i;
  end
  // moves only while clock low; never stretches the clock
  always @(negedge scl_i) begin
    if (cnt == 4'd9) begin
      cnt = 4'd0;
      if (st == 2'd1) st = hit ? 2'd2 : 2'd0;
      else if (mack) tx = tx + 8'h01;
      else st = 2'd0;
    end
    if (cnt == 4'd8) begin
      hit = sh == {ADDR, 1'b1};
      sda_oe_o = st == 2'd1 && sh[7:1] == ADDR;
    end else begin
      sda_oe_o = st == 2'd2 && !tx[3'd7 - cnt[2:0]];
    end
  end
endmodule // slave_tx_model

// ---- bench/two_wire_master_receiver_monitor.sv ----
`timescale 1ns/100ps
module two_wire_master_receiver_monitor (
  input wire logic clk_i, // system clock
  input wire logic rst_b_i, // sync reset
  input wire logic s_axi_awvalid_i, // write address valid
  input wire logic s_axi_awready_o, // write address ready
  input wire logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic s_axi_arvalid_i, // read address valid
  input wire logic s_axi_arready_o, // read address ready
  input wire logic s_axi_rvalid_o, // read data valid
  input wire logic scl_oe_o, // clock line pull
  input wire logic sda_oe_o, // data line pull
  input wire logic irq_o // interrupt
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ****************
  // assertions
  // ****************
  sequence s_start; $rose(sda_oe_o) && !scl_oe_o; endsequence
  sequence s_stop; $fell(sda_oe_o) && !scl_oe_o; endsequence
  property p_reset;
    disable iff (1'b0) !rst_b_i |=> !scl_oe_o && !sda_oe_o && !s_axi_bvalid_o && !irq_o;
  endproperty
  property p_start; s_start |-> ##[61:63] $rose(scl_oe_o); endproperty
  property p_stop; s_stop |=> (!scl_oe_o && !sda_oe_o) [*8]; endproperty
  property p_high; $fell(scl_oe_o) |=> !scl_oe_o [*8]; endproperty
  property p_stretch; $rose(scl_oe_o) |=> scl_oe_o [*8]; endproperty
  property p_b_next; s_axi_awvalid_i && s_axi_awready_o |=> s_axi_bvalid_o; endproperty
  property p_b_drop; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
  property p_r_next; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  a_start: assert property (p_start) else $error("start timing wrong");
  a_stop: assert property (p_stop) else $error("bus not freed");
  a_high: assert property (p_high) else $error("clock high too short");
  a_stretch: assert property (p_stretch) else $error("clock low too short");
  a_b_next: assert property (p_b_next) else $error("no write response");
  a_b_drop: assert property (p_b_drop) else $error("write response stuck");
  a_r_next: assert property (p_r_next) else $error("no read response");
endmodule // two_wire_master_receiver_monitor
bind two_wire_master_receiver two_wire_master_receiver_monitor i_mon (.*);

// ---- bench/two_wire_master_receiver_tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module two_wire_master_receiver_tb;
  import two_wire_pkg::*;
  localparam logic [7:0] TXD = 8'hA5;
  logic clk_i = 1'b0, rst_b_i = 1'b0, jam = 1'b0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, d;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic scl_o, sda_o, scl_oe_o, sda_oe_o, irq_o, slv_oe;
  int compares = 0, n_mismatch = 0;
  // open drain with pull-ups; jam plays a rival master
  wire scl_i = scl_oe_o !== 1'b1;
  wire sda_i = !(sda_oe_o === 1'b1 || slv_oe || jam);
  always #20 clk_i = !clk_i;
  two_wire_master_receiver i_dut (.*);
  slave_tx_model #(.ADDR(7'h2A), .FIRST(TXD)) i_slave (.scl_i(scl_i), .sda_i(sda_i),
    .sda_oe_o(slv_oe));
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, v};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do @(negedge clk_i); while (!(s_axi_awready_o && s_axi_wready_o));
    @(posedge clk_i);
    s_axi_awvalid_i <= 1'b0;
    s_axi_wvalid_i <= 1'b0;
    do @(negedge clk_i); while (!s_axi_bvalid_o);
    rsp = s_axi_bresp_o;
    @(posedge clk_i);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(negedge clk_i); while (!s_axi_arready_o);
    @(posedge clk_i);
    s_axi_arvalid_i <= 1'b0;
    do @(negedge clk_i); while (!s_axi_rvalid_o);
    d = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    @(posedge clk_i);
    s_axi_rready_i <= 1'b0;
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] code);
    wr(CTRL_OFFSET, c);
    do rd(CTRL_OFFSET); while (d[OP_DONE_BIT] !== 1'b1);
    rd(STATUS_OFFSET);
    `CHK("status", code, d[7:0] & 8'hF8)
  endtask
  task automatic end_sim;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    end_sim;
  end
  // ****************
  // tests
  // ****************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(STATUS_OFFSET);
    `CHK("idle status", 8'hF8, d[7:0])
    rd(8'h40);
    `CHK("bad read", 34'h200000000, {rsp, d})
    wr(8'h40, 8'h01);
    `CHK("bad write", 2'h2, rsp)
    wr(IRQ_ENABLE_OFFSET, 8'h01);
    wr(DATA_OFFSET, 8'h55);
    rd(CTRL_OFFSET);
    `CHK("collision", 1'b1, d[WCOL_BIT])
    rd(IRQ_STATUS_OFFSET);
    `CHK("irq status", 3'h2, d[2:0])
    `CHK("irq masked", 1'b0, irq_o)
    step(8'hA4, 8'h08);
    `CHK("irq raised", 1'b1, irq_o)
    wr(IRQ_CLEAR_OFFSET, 8'h07);
    `CHK("irq cleared", 1'b0, irq_o)
    wr(DATA_OFFSET, 8'h55);
    step(8'hC4, 8'h40);
    step(8'hC4, 8'h50);
    rd(DATA_OFFSET);
    `CHK("byte 1", TXD, d[7:0])
    step(8'h84, 8'h58);
    rd(DATA_OFFSET);
    `CHK("byte 2", TXD + 8'h01, d[7:0])
    step(8'hA4, 8'h10);
    wr(DATA_OFFSET, 8'h54);
    step(8'h84, 8'h18);
    step(8'hA4, 8'h10);
    wr(DATA_OFFSET, 8'h57);
    step(8'h84, 8'h48);
    step(8'hB4, 8'h08);
    jam <= 1'b1;
    wr(DATA_OFFSET, 8'h55);
    step(8'h84, 8'h38);
    jam <= 1'b0;
    rd(CTRL_OFFSET);
    `CHK("released", 2'b00, {scl_oe_o, sda_oe_o})
    `CHK("drive low", 2'b00, {scl_o, sda_o})
    step(8'hA4, 8'h08);
    wr(DATA_OFFSET, 8'h57);
    step(8'h84, 8'h48);
    wr(CTRL_OFFSET, 8'h94);
    do rd(STATUS_OFFSET); while (d[7:0] !== 8'hF8);
    rd(CTRL_OFFSET);
    `CHK("stop cleared", 1'b0, d[STOP_BIT])
    end_sim;
  end
endmodule // two_wire_master_receiver_tb

// ---- core/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i, // system clock
  input wire logic rst_b_i, // sync reset, active low
  input wire logic [WIDTH-1:0] async_i, // raw pin levels
  output logic [WIDTH-1:0] sync_o // synchronised levels
);
  logic [WIDTH-1:0] meta;

  // idle bus is high, so reset to ones
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta <= '1;
      sync_o <= '1;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // pin_sync

// ---- core/quarter_tick.sv ----
`timescale 1ns/100ps
module quarter_tick #(
  parameter int CYCLES = 62
) (
  input wire logic clk_i, // system clock
  input wire logic rst_b_i, // sync reset, active low
  input wire logic run_i, // count while high, restart when low
  output logic tick_o // one-cycle pulse every CYCLES clocks
);
  logic [15:0] count;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !run_i) begin
      count <= 16'h0000;
      tick_o <= 1'h0;
    end else if (count == 16'(CYCLES - 1)) begin
      count <= 16'h0000;
      tick_o <= 1'h1;
    end else begin
      count <= count + 16'h0001;
      tick_o <= 1'h0;
    end
  end
endmodule // quarter_tick

// ---- core/two_wire_master_receiver.sv ----
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// - address byte with read bit enters receive mode, write bit enters transmit mode.
// - enable, start request and done-clear wait for an idle bus, then START.
// - after START, set op-done flag and status 0x08.
// - after address plus read: 0x40 on ACK, 0x48 on NACK, 0x38 lost.
// - writing one to op-done clears it and lets the next bus action run.
// - after each received byte: 0x50 if ACK returned, 0x58 if NACK returned.
// - in 0x40/0x50 a plain clear receives a byte, ACK per ack-enable bit.
// - clear with stop request and enable, start low, sends a STOP.
// - start request with clear sends repeated START without STOP, status 0x10.
// - after repeated START the bus stays owned for any address or direction.
// - in 0x08/0x10 an address with write bit is sent, then transmit mode.
// - in 0x38 clear releases bus; with start request a START waits for idle.
// - in 0x48/0x58 start, stop, or stop-then-start; stop request self-clears.
// - data writes only while op-done set, otherwise ignored with collision flag.
module two_wire_master_receiver (
  input wire logic clk_i, // system clock, 25 MHz
  input wire logic rst_b_i, // sync reset, active low
  input wire logic [two_wire_pkg::ADDR_W-1:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [two_wire_pkg::ADDR_W-1:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  input wire logic scl_i, // clock line level
  output logic scl_o, // clock line drive value, always low
  output logic scl_oe_o, // high while pulling clock line low
  input wire logic sda_i, // data line level
  output logic sda_o, // data line drive value, always low
  output logic sda_oe_o, // high while pulling data line low
  output logic irq_o // level interrupt
);
  import two_wire_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [1:0] pins_s;
  logic scl_s, sda_s, scl_q, sda_q, bus_busy;
  logic tick, engine_run;
  ctrl_type ctrl;
  logic op_done, wcol;
  logic [7:0] data_reg, status, shift;
  logic [IRQ_W-1:0] irq_status, irq_enable_reg, irq_events;
  state_type state;
  logic [1:0] phase;
  logic [3:0] bit_cnt;
  logic scl_low, sda_low, owned, repeated, rx_mode, addr_phase, ack_low;
  logic done_set, stop_done, arb_set, rx_load;
  logic wr_fire, rd_fire, ctrl_wr, data_wr, go, data_accept;
  logic wd_start, wd_stop, wd_enable;
  logic sending, tx_bit;
  logic [7:0] ctrl_byte, byte_code;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == CTRL_OFFSET) || (a == STATUS_OFFSET) || (a == DATA_OFFSET) ||
           (a == IRQ_STATUS_OFFSET) || (a == IRQ_CLEAR_OFFSET) ||
           (a == IRQ_ENABLE_OFFSET);
  endfunction

  // ****************************************************************
  // pins and bus watch
  // ****************************************************************
  pin_sync #(.WIDTH(2)) u_pin_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i({scl_i, sda_i}),
    .sync_o(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // open drain: drive value fixed low, enable does the work
  assign scl_o = 1'h0;
  assign sda_o = 1'h0;
  assign scl_oe_o = scl_low;
  assign sda_oe_o = sda_low;

  // busy from START until STOP seen by anyone on the bus
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      bus_busy <= 1'h0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (scl_s && scl_q && sda_q && !sda_s) begin
        bus_busy <= 1'h1;
      end else if (scl_s && scl_q && !sda_q && sda_s) begin
        bus_busy <= 1'h0;
      end
    end
  end

  assign engine_run = (state == ST_START) || (state == ST_BYTE) || (state == ST_STOP);

  quarter_tick #(.CYCLES(QUARTER_CYCLES)) u_quarter_tick (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(engine_run),
    .tick_o(tick)
  );

  // ****************************************************************
  // register bus
  // ****************************************************************
  // address and data are taken together in one edge
  assign wr_fire = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
  assign s_axi_awready_o = wr_fire;
  assign s_axi_wready_o = wr_fire;
  assign rd_fire = s_axi_arvalid_i && !s_axi_rvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  assign ctrl_wr = wr_fire && s_axi_wstrb_i[0] && (s_axi_awaddr_i == CTRL_OFFSET);
  assign data_wr = wr_fire && s_axi_wstrb_i[0] && (s_axi_awaddr_i == DATA_OFFSET);
  assign wd_start = s_axi_wdata_i[START_BIT];
  assign wd_stop = s_axi_wdata_i[STOP_BIT];
  assign wd_enable = s_axi_wdata_i[IFACE_ENABLE_BIT];
  assign go = ctrl_wr && s_axi_wdata_i[OP_DONE_BIT];
  assign data_accept = data_wr && op_done;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid_o <= 1'h0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'h1;
      s_axi_bresp_o <= mapped(s_axi_awaddr_i) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'h0;
    end
  end

  assign ctrl_byte = {op_done, ctrl.ack_enable, ctrl.start_request, ctrl.stop_request,
                      wcol, ctrl.iface_enable, 1'h0, ctrl.irq_enable};

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid_o <= 1'h0;
      s_axi_rresp_o <= RESP_OKAY;
      s_axi_rdata_o <= 32'h0000_0000;
    end else if (rd_fire) begin
      s_axi_rvalid_o <= 1'h1;
      s_axi_rresp_o <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr_i)
        CTRL_OFFSET: s_axi_rdata_o <= {24'h00_0000, ctrl_byte};
        STATUS_OFFSET: s_axi_rdata_o <= {24'h00_0000, status};
        DATA_OFFSET: s_axi_rdata_o <= {24'h00_0000, data_reg};
        IRQ_STATUS_OFFSET: s_axi_rdata_o <= {29'h0000_0000, irq_status};
        IRQ_ENABLE_OFFSET: s_axi_rdata_o <= {29'h0000_0000, irq_enable_reg};
        default: s_axi_rdata_o <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'h0;
    end
  end

  // ****************************************************************
  // control, flags and data
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl <= '0;
    end else begin
      if (ctrl_wr) begin
        ctrl.ack_enable <= s_axi_wdata_i[ACK_ENABLE_BIT];
        ctrl.start_request <= wd_start;
        ctrl.stop_request <= wd_stop;
        ctrl.iface_enable <= wd_enable;
        ctrl.irq_enable <= s_axi_wdata_i[IRQ_ENABLE_BIT];
      end
      if (stop_done) begin
        ctrl.stop_request <= 1'h0;
      end
    end
  end

  // a completion in the same cycle as the clearing write wins
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      op_done <= 1'h0;
    end else if (done_set) begin
      op_done <= 1'h1;
    end else if (go) begin
      op_done <= 1'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wcol <= 1'h0;
    end else if (data_wr && !op_done) begin
      wcol <= 1'h1;
    end else if (data_accept) begin
      wcol <= 1'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      data_reg <= 8'h00;
    end else if (data_accept) begin
      data_reg <= s_axi_wdata_i[7:0];
    end else if (rx_load) begin
      data_reg <= shift;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign irq_events = {arb_set, data_wr && !op_done, done_set};

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_status <= '0;
      irq_enable_reg <= '0;
    end else begin
      if (wr_fire && s_axi_wstrb_i[0] && (s_axi_awaddr_i == IRQ_ENABLE_OFFSET)) begin
        irq_enable_reg <= s_axi_wdata_i[IRQ_W-1:0];
      end
      // set beats clear
      if (wr_fire && s_axi_wstrb_i[0] && (s_axi_awaddr_i == IRQ_CLEAR_OFFSET)) begin
        irq_status <= (irq_status & ~s_axi_wdata_i[IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
    end
  end

  // control-register enable also opens the done source
  assign irq_o = |(irq_status & (irq_enable_reg |
                 {{(IRQ_W-1){1'h0}}, ctrl.irq_enable}));

  // ****************************************************************
  // bus engine
  // ****************************************************************
  // sending is false only for data bytes of a read
  assign sending = !(rx_mode && !addr_phase);
  always_comb begin
    if (bit_cnt != LAST_BIT) begin
      tx_bit = sending ? shift[7] : 1'h1;
    end else begin
      tx_bit = sending ? 1'h1 : !ctrl.ack_enable;
    end
  end

  always_comb begin
    if (addr_phase) begin
      if (rx_mode) begin
        byte_code = ack_low ? CODE_RADDR_ACK : CODE_RADDR_NACK;
      end else begin
        byte_code = ack_low ? CODE_WADDR_ACK : CODE_WADDR_NACK;
      end
    end else if (rx_mode) begin
      byte_code = ack_low ? CODE_RXDATA_ACK : CODE_RXDATA_NACK;
    end else begin
      byte_code = ack_low ? CODE_TXDATA_ACK : CODE_TXDATA_NACK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      status <= CODE_IDLE;
      scl_low <= 1'h0;
      sda_low <= 1'h0;
      owned <= 1'h0;
      repeated <= 1'h0;
      rx_mode <= 1'h0;
      addr_phase <= 1'h0;
      ack_low <= 1'h0;
      done_set <= 1'h0;
      stop_done <= 1'h0;
      arb_set <= 1'h0;
      rx_load <= 1'h0;
    end else begin
      done_set <= 1'h0;
      stop_done <= 1'h0;
      arb_set <= 1'h0;
      rx_load <= 1'h0;
      if (tick) begin
        phase <= phase + 2'h1;
      end
      // the enabling write may carry the first start, so its go is not lost
      if (!ctrl.iface_enable && !(ctrl_wr && wd_enable)) begin
        // disabling drops the bus at once, no STOP
        state <= ST_IDLE;
        phase <= 2'h0;
        scl_low <= 1'h0;
        sda_low <= 1'h0;
        owned <= 1'h0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (go && wd_start && wd_enable) begin
              state <= ST_WAIT_FREE;
            end
          end
          ST_WAIT_FREE: begin
            if (!bus_busy) begin
              state <= ST_START;
              repeated <= 1'h0;
            end
          end
          ST_START: begin
            if (tick) begin
              unique case (phase)
                2'h0: sda_low <= 1'h0;
                2'h1: scl_low <= 1'h0;
                2'h2: sda_low <= 1'h1;
                2'h3: begin
                  scl_low <= 1'h1;
                  owned <= 1'h1;
                  status <= repeated ? CODE_RSTART : CODE_START;
                  done_set <= 1'h1;
                  state <= ST_HOLD;
                end
              endcase
            end
          end
          ST_HOLD: begin
            if (go) begin
              if (status == CODE_ARB_LOST) begin
                owned <= 1'h0;
                if (wd_start) begin
                  state <= ST_WAIT_FREE;
                end else begin
                  state <= ST_IDLE;
                  status <= CODE_IDLE;
                end
              end else if (wd_stop) begin
                state <= ST_STOP;
              end else if (wd_start) begin
                state <= ST_START;
                repeated <= 1'h1;
              end else if (status == CODE_START || status == CODE_RSTART) begin
                shift <= data_reg;
                rx_mode <= data_reg[0];
                addr_phase <= 1'h1;
                bit_cnt <= 4'h0;
                state <= ST_BYTE;
              end else if (rx_mode && (status == CODE_RADDR_ACK ||
                                       status == CODE_RXDATA_ACK)) begin
                addr_phase <= 1'h0;
                bit_cnt <= 4'h0;
                state <= ST_BYTE;
              end else if (!rx_mode && (status == CODE_WADDR_ACK ||
                                        status == CODE_WADDR_NACK ||
                                        status == CODE_TXDATA_ACK ||
                                        status == CODE_TXDATA_NACK)) begin
                shift <= data_reg;
                addr_phase <= 1'h0;
                bit_cnt <= 4'h0;
                state <= ST_BYTE;
              end
            end
          end
          ST_BYTE: begin
            if (tick) begin
              unique case (phase)
                2'h0: sda_low <= !tx_bit;
                2'h1: scl_low <= 1'h0;
                2'h2: begin
                  if (sending && tx_bit && !sda_s && bit_cnt != LAST_BIT) begin
                    // another master pulled low: back off at once
                    scl_low <= 1'h0;
                    sda_low <= 1'h0;
                    owned <= 1'h0;
                    status <= CODE_ARB_LOST;
                    done_set <= 1'h1;
                    arb_set <= 1'h1;
                    phase <= 2'h0;
                    state <= ST_HOLD;
                  end else if (bit_cnt == LAST_BIT) begin
                    ack_low <= !sda_s;
                  end else begin
                    shift <= {shift[6:0], sda_s};
                  end
                end
                2'h3: begin
                  scl_low <= 1'h1;
                  if (bit_cnt == LAST_BIT) begin
                    status <= byte_code;
                    done_set <= 1'h1;
                    rx_load <= !sending;
                    state <= ST_HOLD;
                  end else begin
                    bit_cnt <= bit_cnt + 4'h1;
                  end
                end
              endcase
            end
          end
          ST_STOP: begin
            if (tick) begin
              unique case (phase)
                2'h0: sda_low <= 1'h1;
                2'h1: scl_low <= 1'h0;
                2'h2: sda_low <= 1'h0;
                2'h3: begin
                  owned <= 1'h0;
                  stop_done <= 1'h1;
                  status <= CODE_IDLE;
                  state <= ctrl.start_request ? ST_WAIT_FREE : ST_IDLE;
                end
              endcase
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // two_wire_master_receiver

// ---- core/two_wire_pkg.sv ----
package two_wire_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int BIT_PERIOD_NS = 10000;
  // longest quarter bit, so rounded down
  localparam int QUARTER_CYCLES = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] DATA_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h14;

  // serial_control field positions
  localparam int OP_DONE_BIT = 7;
  localparam int ACK_ENABLE_BIT = 6;
  localparam int START_BIT = 5;
  localparam int STOP_BIT = 4;
  localparam int WCOL_BIT = 3;
  localparam int IFACE_ENABLE_BIT = 2;
  localparam int IRQ_ENABLE_BIT = 0;

  // interrupt status / clear / enable layout
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_WCOL_BIT = 1;
  localparam int IRQ_ARB_BIT = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // status codes, prescaler field reads as zero
  // ****************************************************************
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RSTART = 8'h10;
  localparam logic [7:0] CODE_WADDR_ACK = 8'h18;
  localparam logic [7:0] CODE_WADDR_NACK = 8'h20;
  localparam logic [7:0] CODE_TXDATA_ACK = 8'h28;
  localparam logic [7:0] CODE_TXDATA_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB_LOST = 8'h38;
  localparam logic [7:0] CODE_RADDR_ACK = 8'h40;
  localparam logic [7:0] CODE_RADDR_NACK = 8'h48;
  localparam logic [7:0] CODE_RXDATA_ACK = 8'h50;
  localparam logic [7:0] CODE_RXDATA_NACK = 8'h58;
  localparam logic [7:0] CODE_IDLE = 8'hF8;

  localparam logic [3:0] LAST_BIT = 4'h8;

  typedef struct packed {
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic iface_enable;
    logic irq_enable;
  } ctrl_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT_FREE = 3'h1,
    ST_START = 3'h2,
    ST_BYTE = 3'h3,
    ST_HOLD = 3'h4,
    ST_STOP = 3'h5
  } state_type;

endpackage
